// file: rtl/vr_mode_pkg.sv
// constants for the regulator mode and output-good block
// assumes a 20 MHz core_clk and a plain register port
package vr_mode_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int CTRL_ONE_PH_BIT = 0;
    localparam int CTRL_FLT_CLR_BIT = 1;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SKIP_BIT = 8;
    localparam int STAT_TWO_PH_BIT = 9;
    localparam int STAT_BLANK_BIT = 10;
    localparam int STAT_FAULT_BIT = 11;
    localparam int STAT_PGDONE_BIT = 12;
    localparam int STAT_GOOD_BIT = 13;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int PWM_HOLD_NS = 20000;
    localparam int PWM_HOLD_CYC =
        (PWM_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_NS = 20000;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PG_HOLD_MS = 5;
    localparam int PG_HOLD_CYC = PG_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TMR_W = 17;
    localparam int SYNC_N = 13;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_OFF = 7'h01,
        ST_START = 7'h02,
        ST_BOOT = 7'h04,
        ST_B2V = 7'h08,
        ST_RUN = 7'h10,
        ST_SOFTOFF = 7'h20,
        ST_FAULT = 7'h40
    } seq_state_t;
endpackage

// file: rtl/timer_if.sv
// start and busy handshake between the sequencer and a countdown timer
// assumes timer and user share core_clk
`timescale 1ns/1ps
interface timer_if;
    logic start;
    logic [vr_mode_pkg::TMR_W-1:0] load;
    logic busy;
    modport user (output start, output load, input busy);
    modport tmr (input start, input load, output busy);
endinterface

// file: rtl/countdown_timer.sv
// countdown timer, busy while the count is above zero
// assumes start is a one-cycle pulse from core_clk logic
`timescale 1ns/1ps
module countdown_timer (
    input wire logic core_clk,
    input wire logic resetn,
    timer_if.tmr t
);
    logic [vr_mode_pkg::TMR_W-1:0] cnt_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else if (t.start) begin
            cnt_r <= t.load;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign t.busy = (cnt_r != '0);
endmodule

// file: rtl/vr_mode_ctrl.sv
// mode selection, clock-enable and output-good logic of a two-phase
// core regulator controller
// assumes analog status arrives as asynchronous levels on pins
`timescale 1ns/1ps
module vr_mode_ctrl #(
    parameter int PG_HOLD_CYCLES = vr_mode_pkg::PG_HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic skip_request,
    input wire logic power_state_hint,
    input wire logic shutdown_n,
    input wire logic fb_under,
    input wire logic fb_over,
    input wire logic code_trans_active,
    input wire logic code_trans_down,
    input wire logic slew_active,
    input wire logic period_current_low,
    input wire logic phase2_tied_core,
    input wire logic boot_reached,
    input wire logic code_mode_go,
    input wire logic ramp_down_done,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic clock_enable_out_n,
    output logic output_good_out,
    output logic output_good_oe,
    output logic pwm_forced,
    output logic two_phase,
    output logic controller_en,
    output logic gate_drive_en,
    output logic ovp_transitional,
    output logic slow_slew,
    output logic open_pin_fault
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [vr_mode_pkg::SYNC_N-1:0] raw, meta_r, sync_r;
    assign raw = {skip_request, power_state_hint, shutdown_n, fb_under,
                  fb_over, code_trans_active, code_trans_down, slew_active,
                  period_current_low, phase2_tied_core, boot_reached,
                  code_mode_go, ramp_down_done};

    genvar gi;
    generate
        for (gi = 0; gi < vr_mode_pkg::SYNC_N; gi++) begin : g_sync
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= raw[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    logic s_skip, s_hint, s_shutdown_n_n, s_under, s_over, s_trans, s_down;
    logic s_slew, s_ton_low, s_p2tied, s_boot, s_go, s_ramp_done;
    assign {s_skip, s_hint, s_shutdown_n_n, s_under, s_over, s_trans, s_down,
            s_slew, s_ton_low, s_p2tied, s_boot, s_go, s_ramp_done} = sync_r;

    // ------------------------------------------------------------
    // registers and timers
    // ------------------------------------------------------------
    vr_mode_pkg::seq_state_t state_r, state_nxt;
    logic [31:0] ctrl_r;
    logic fault_r, skip_mode_r, blank_r, trans_d_r, pg_done_r, good_nxt;
    logic one_phase, trans_rise, in_reg;

    timer_if hold_t ();
    timer_if blank_t ();
    timer_if pg_t ();
    countdown_timer u_hold (.core_clk(core_clk), .resetn(resetn),
                            .t(hold_t));
    countdown_timer u_blank (.core_clk(core_clk), .resetn(resetn),
                             .t(blank_t));
    countdown_timer u_pg (.core_clk(core_clk), .resetn(resetn), .t(pg_t));

    assign one_phase = s_p2tied | ctrl_r[vr_mode_pkg::CTRL_ONE_PH_BIT];
    assign trans_rise = s_trans & ~trans_d_r;
    assign in_reg = ~s_under & (~s_over | blank_r);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            vr_mode_pkg::ST_OFF: begin
                if (s_shutdown_n_n && !fault_r) begin
                    state_nxt = vr_mode_pkg::ST_START;
                end
            end
            vr_mode_pkg::ST_START: begin
                if (s_boot) begin
                    state_nxt = vr_mode_pkg::ST_BOOT;
                end
            end
            vr_mode_pkg::ST_BOOT: begin
                if (s_go) begin
                    state_nxt = vr_mode_pkg::ST_B2V;
                end
            end
            vr_mode_pkg::ST_B2V: begin
                if (!s_slew && !s_trans) begin
                    state_nxt = vr_mode_pkg::ST_RUN;
                end
            end
            vr_mode_pkg::ST_RUN: begin
                state_nxt = vr_mode_pkg::ST_RUN;
            end
            vr_mode_pkg::ST_SOFTOFF: begin
                if (s_ramp_done) begin
                    state_nxt = vr_mode_pkg::ST_OFF;
                end
            end
            vr_mode_pkg::ST_FAULT: begin
                if (!s_shutdown_n_n) begin
                    state_nxt = vr_mode_pkg::ST_OFF;
                end
            end
            default: state_nxt = vr_mode_pkg::ST_OFF;
        endcase
        if (state_r != vr_mode_pkg::ST_OFF &&
            state_r != vr_mode_pkg::ST_FAULT) begin
            if (s_ton_low) begin
                state_nxt = vr_mode_pkg::ST_FAULT;
            end else if (!s_shutdown_n_n &&
                         state_r != vr_mode_pkg::ST_SOFTOFF) begin
                state_nxt = vr_mode_pkg::ST_SOFTOFF;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= vr_mode_pkg::ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // pulse-skip request tracking
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            skip_mode_r <= 1'b0;
        end else if (s_skip) begin
            skip_mode_r <= 1'b1;
        end else if (in_reg) begin
            skip_mode_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // timers: post-transition PWM hold, blanking, output-good hold
    // ------------------------------------------------------------
    assign hold_t.start = (state_r == vr_mode_pkg::ST_B2V) &&
                          (state_nxt == vr_mode_pkg::ST_RUN);
    assign hold_t.load = vr_mode_pkg::TMR_W'(vr_mode_pkg::PWM_HOLD_CYC);
    assign blank_t.start = trans_rise;
    assign blank_t.load = vr_mode_pkg::TMR_W'(vr_mode_pkg::BLANK_CYC);
    assign pg_t.start = (state_r == vr_mode_pkg::ST_BOOT) &&
                        (state_nxt == vr_mode_pkg::ST_B2V);
    assign pg_t.load = vr_mode_pkg::TMR_W'(PG_HOLD_CYCLES);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trans_d_r <= 1'b0;
        end else begin
            trans_d_r <= s_trans;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            blank_r <= 1'b0;
        end else if (state_r != vr_mode_pkg::ST_RUN) begin
            blank_r <= 1'b0;
        end else if (trans_rise && s_down && skip_mode_r) begin
            blank_r <= 1'b1;
        end else if (!blank_t.busy && !s_trans && !s_under) begin
            blank_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pg_done_r <= 1'b0;
        end else if (state_r == vr_mode_pkg::ST_OFF ||
                     state_r == vr_mode_pkg::ST_START ||
                     state_r == vr_mode_pkg::ST_BOOT) begin
            pg_done_r <= 1'b0;
        end else if (!pg_t.busy && !pg_t.start) begin
            pg_done_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // open-pin fault latch, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fault_r <= 1'b0;
        end else if (s_ton_low && state_r != vr_mode_pkg::ST_OFF) begin
            fault_r <= 1'b1;
        end else if (reg_wr && reg_addr == vr_mode_pkg::CTRL_OFS &&
                     reg_wdata[vr_mode_pkg::CTRL_FLT_CLR_BIT]) begin
            fault_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output good and clock enable
    // ------------------------------------------------------------
    always_comb begin
        good_nxt = 1'b0;
        if ((state_r == vr_mode_pkg::ST_RUN ||
             state_r == vr_mode_pkg::ST_B2V) && pg_done_r) begin
            if (s_slew) begin
                good_nxt = 1'b1;
            end else begin
                good_nxt = ~s_under & (~s_over | blank_r | s_skip);
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            output_good_oe <= 1'b1;
            output_good_out <= 1'b0;
            clock_enable_out_n <= 1'b1;
        end else begin
            output_good_oe <= ~good_nxt;
            output_good_out <= 1'b0;
            if (state_r != vr_mode_pkg::ST_RUN &&
                state_r != vr_mode_pkg::ST_B2V) begin
                clock_enable_out_n <= 1'b1;
            end else if (s_trans) begin
                clock_enable_out_n <= 1'b0;
            end else if (pg_done_r) begin
                clock_enable_out_n <= ~good_nxt;
            end else begin
                clock_enable_out_n <= s_under | (s_over & ~s_skip);
            end
        end
    end

    // ------------------------------------------------------------
    // mode, phase count and drive outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pwm_forced <= 1'b0;
            two_phase <= 1'b0;
            controller_en <= 1'b0;
            gate_drive_en <= 1'b0;
            ovp_transitional <= 1'b0;
            slow_slew <= 1'b0;
            open_pin_fault <= 1'b0;
        end else begin
            open_pin_fault <= fault_r;
            ovp_transitional <= blank_r;
            slow_slew <= (state_r == vr_mode_pkg::ST_START) ||
                         (state_r == vr_mode_pkg::ST_SOFTOFF);
            controller_en <= (state_r != vr_mode_pkg::ST_OFF) &&
                             (state_r != vr_mode_pkg::ST_FAULT);
            gate_drive_en <= (state_r != vr_mode_pkg::ST_OFF) &&
                             (state_r != vr_mode_pkg::ST_FAULT);
            case (state_r)
                vr_mode_pkg::ST_START, vr_mode_pkg::ST_BOOT: begin
                    pwm_forced <= 1'b0;
                    two_phase <= ~one_phase;
                end
                vr_mode_pkg::ST_B2V, vr_mode_pkg::ST_SOFTOFF: begin
                    pwm_forced <= 1'b1;
                    two_phase <= ~one_phase;
                end
                vr_mode_pkg::ST_RUN: begin
                    if (hold_t.busy) begin
                        pwm_forced <= 1'b1;
                        two_phase <= ~one_phase;
                    end else if (skip_mode_r) begin
                        pwm_forced <= 1'b0;
                        two_phase <= 1'b0;
                    end else begin
                        pwm_forced <= 1'b1;
                        two_phase <= s_hint & ~one_phase;
                    end
                end
                default: begin
                    pwm_forced <= 1'b0;
                    two_phase <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= vr_mode_pkg::CTRL_RST;
        end else if (reg_wr && reg_addr == vr_mode_pkg::CTRL_OFS) begin
            ctrl_r <= {31'h0000_0000, reg_wdata[vr_mode_pkg::CTRL_ONE_PH_BIT]};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd && reg_addr == vr_mode_pkg::CTRL_OFS) begin
            reg_rdata <= ctrl_r;
        end else if (reg_rd && reg_addr == vr_mode_pkg::STAT_OFS) begin
            reg_rdata <= 32'h0000_0000;
            reg_rdata[vr_mode_pkg::STAT_STATE_LSB +: 7] <= state_r;
            reg_rdata[vr_mode_pkg::STAT_SKIP_BIT] <= skip_mode_r;
            reg_rdata[vr_mode_pkg::STAT_TWO_PH_BIT] <= two_phase;
            reg_rdata[vr_mode_pkg::STAT_BLANK_BIT] <= blank_r;
            reg_rdata[vr_mode_pkg::STAT_FAULT_BIT] <= fault_r;
            reg_rdata[vr_mode_pkg::STAT_PGDONE_BIT] <= pg_done_r;
            reg_rdata[vr_mode_pkg::STAT_GOOD_BIT] <= ~output_good_oe;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    skip_entry_a: assert property (s_skip |=> skip_mode_r)
        else $error("skip request did not enter pulse-skip");
    skip_exit_a: assert property (skip_mode_r && !s_skip && s_under
        |=> skip_mode_r)
        else $error("skip left while out of regulation");
    blank_ovp_a: assert property ($rose(blank_r) |=> ovp_transitional)
        else $error("transitional overvoltage level not applied");
    boot_mode_a: assert property (state_r == vr_mode_pkg::ST_BOOT && !one_phase
        |=> !pwm_forced && two_phase)
        else $error("boot not in two-phase pulse-skip");
    b2v_pwm_a: assert property (hold_t.start |=> pwm_forced [*8])
        else $error("pwm not held after boot transition");
    skip_phase_a: assert property (state_r == vr_mode_pkg::ST_RUN &&
        !hold_t.busy && skip_mode_r |=> !two_phase && !pwm_forced)
        else $error("skip mode not one-phase pulse-skip");
    fault_kill_a: assert property (s_ton_low &&
        state_r == vr_mode_pkg::ST_RUN |-> ##2 !gate_drive_en &&
        open_pin_fault)
        else $error("open pin fault did not kill drives");
    clock_enable_out_n_trans_a: assert property (s_trans && s_shutdown_n_n && !s_ton_low &&
        state_r == vr_mode_pkg::ST_RUN |=> !clock_enable_out_n)
        else $error("clock enable not asserted in transition");
    pg_shutdown_n_a: assert property (state_r == vr_mode_pkg::ST_OFF
        |=> output_good_oe)
        else $error("output good not low in shutdown");
    pg_slew_a: assert property (state_r == vr_mode_pkg::ST_RUN && pg_done_r
        && s_slew |=> !output_good_oe)
        else $error("output good not released during slew");
endmodule

// file: tb/host_ramp_model.sv
// host-side model: shutdown control and analog ramp completion
// assumes it shares core_clk with the block; ramp length is a parameter
`timescale 1ns/1ps
module host_ramp_model #(
    parameter int RAMP = 20
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic shutdown_n,
    output logic boot_reached,
    output logic ramp_down_done
);
    logic [7:0] cnt_r;
    logic last_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 8'h00;
            last_r <= 1'b0;
        end else begin
            last_r <= shutdown_n;
            if (last_r != shutdown_n) begin
                cnt_r <= 8'h00;
            end else if (cnt_r < 8'(RAMP)) begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
    // ramp up to boot level, or down to zero, takes RAMP cycles
    assign boot_reached = shutdown_n && (cnt_r == 8'(RAMP));
    assign ramp_down_done = !shutdown_n && (cnt_r == 8'(RAMP));
endmodule

// file: tb/tb_top.sv
// self-checking bench for the regulator mode and output-good block
// assumes 20 MHz core_clk; output-good hold shortened to 50 cycles
`timescale 1ns/1ps
module tb_top;
    typedef struct {bit pin; logic [31:0] e; logic [31:0] m;} note_t;
    note_t notes[$];
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic skip_request, power_state_hint, shutdown_n, fb_under, fb_over;
    logic code_trans_active, code_trans_down, slew_active;
    logic period_current_low, phase2_tied_core, code_mode_go;
    logic boot_reached, ramp_down_done, reg_wr, reg_rd, rd_d, snap;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed;
    logic clock_enable_out_n, output_good_out, output_good_oe, pwm_forced;
    logic two_phase, controller_en, gate_drive_en, ovp_transitional;
    logic slow_slew, open_pin_fault;
    logic [8:0] pins;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    assign pins = {clock_enable_out_n, output_good_oe, pwm_forced, two_phase,
        controller_en, gate_drive_en, ovp_transitional, slow_slew,
        open_pin_fault};
    always #25 core_clk = ~core_clk;
    vr_mode_ctrl #(.PG_HOLD_CYCLES(50)) u_vr_mode_ctrl (.*);
    host_ramp_model #(.RAMP(20)) u_host_ramp_model (.*);
    // ------------------------------------------------------------
    // checking side
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic compare(input logic [31:0] seen, input string what);
        note_t n;
        n = notes.pop_front();
        checks_done++;
        if ((seen & n.m) !== (n.e & n.m)) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, n.e & n.m,
                seen & n.m);
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        rd_d <= reg_rd;
        if (rd_d === 1'b1) begin
            compare(reg_rdata, "rdata");
        end
        if (snap === 1'b1) begin
            compare({23'h0, pins}, "pins");
            checks_done++;
            if (output_good_out !== 1'b0) begin
                miscompares++;
                $display("mismatch output_good_out expected 0 seen %b",
                    output_good_out);
            end
        end
        if (cycles > 5000) begin
            miscompares++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // driving side
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        notes.push_back('{1'b0, e, m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic pin(input logic [8:0] e, m);
        notes.push_back('{1'b1, {23'h0, e}, {23'h0, m}});
        snap <= 1'b1;
        cyc(1);
        snap <= 1'b0;
        cyc(1);
    endtask
    initial begin
        logic [31:0] v;
        logic [2:0] b;
        logic o;
        seed = 32'h0000_8DAF;
        {skip_request, power_state_hint, fb_under, fb_over} = '0;
        {code_trans_active, code_trans_down, slew_active, code_mode_go} = '0;
        {period_current_low, phase2_tied_core, shutdown_n} = '0;
        {reg_wr, reg_rd, snap, reg_addr, reg_wdata} = '0;
        cyc(20);
        resetn <= 1'b1;
        cyc(1);
        pin(9'h180, 9'h1FF);
        rd(vr_mode_pkg::STAT_OFS, 32'h1, 32'h287F);
        rd(vr_mode_pkg::CTRL_OFS, vr_mode_pkg::CTRL_RST, 32'hFFFF_FFFF);
        rd(8'h08, 32'h0, 32'hFFFF_FFFF);
        // startup and boot ignore the skip request
        skip_request <= 1'b1;
        shutdown_n <= 1'b1;
        cyc(6);
        pin(9'h1A2, 9'h1E2);
        cyc(30);
        rd(vr_mode_pkg::STAT_OFS, 32'h4, 32'h7F);
        pin(9'h1A0, 9'h1E2);
        code_mode_go <= 1'b1;
        code_trans_active <= 1'b1;
        slew_active <= 1'b1;
        cyc(6);
        pin(9'h0C0, 9'h1C0);
        code_trans_active <= 1'b0;
        slew_active <= 1'b0;
        cyc(24);
        pin(9'h080, 9'h080);
        rd(vr_mode_pkg::STAT_OFS, 32'h10, 32'h7F);
        cyc(50);
        pin(9'h040, 9'h1C0);
        cyc(296);
        pin(9'h040, 9'h040);
        cyc(40);
        pin(9'h000, 9'h060);
        // all skip, hint and phase-2 combinations, then random ones
        for (int i = 0; i < 16; i++) begin
            v = xs();
            b = (i < 8) ? i[2:0] : v[2:0];
            o = (i >= 8) & v[3];
            wr(vr_mode_pkg::CTRL_OFS, {31'h0, o});
            skip_request <= b[0];
            power_state_hint <= b[1];
            phase2_tied_core <= b[2];
            cyc(6);
            pin({2'b00, ~b[0], ~b[0] & b[1] & ~b[2] & ~o, 5'h00}, 9'h060);
        end
        wr(vr_mode_pkg::CTRL_OFS, 32'h0);
        skip_request <= 1'b1;
        cyc(6);
        fb_under <= 1'b1;
        skip_request <= 1'b0;
        cyc(8);
        pin(9'h180, 9'h1C0);
        fb_under <= 1'b0;
        cyc(6);
        pin(9'h040, 9'h1C0);
        skip_request <= 1'b1;
        fb_over <= 1'b1;
        cyc(6);
        pin(9'h000, 9'h180);
        fb_over <= 1'b0;
        code_trans_active <= 1'b1;
        slew_active <= 1'b1;
        fb_under <= 1'b1;
        cyc(6);
        pin(9'h000, 9'h184);
        code_trans_active <= 1'b0;
        slew_active <= 1'b0;
        fb_under <= 1'b0;
        code_trans_down <= 1'b1;
        cyc(6);
        code_trans_active <= 1'b1;
        slew_active <= 1'b1;
        cyc(6);
        pin(9'h004, 9'h004);
        code_trans_active <= 1'b0;
        slew_active <= 1'b0;
        fb_under <= 1'b1;
        cyc(200);
        rd(vr_mode_pkg::STAT_OFS, 32'h400, 32'h400);
        cyc(300);
        pin(9'h004, 9'h004);
        fb_under <= 1'b0;
        code_trans_down <= 1'b0;
        cyc(8);
        pin(9'h000, 9'h004);
        shutdown_n <= 1'b0;
        cyc(6);
        pin(9'h1C2, 9'h1C2);
        cyc(30);
        rd(vr_mode_pkg::STAT_OFS, 32'h1, 32'h7F);
        shutdown_n <= 1'b1;
        cyc(6);
        period_current_low <= 1'b1;
        cyc(6);
        pin(9'h001, 9'h019);
        period_current_low <= 1'b0;
        cyc(6);
        pin(9'h001, 9'h019);
        rd(vr_mode_pkg::STAT_OFS, 32'h840, 32'h87F);
        give_verdict();
    end
endmodule
